// ==== common/hpw_pkg.sv ====
// constants for the heat pulse width calculator
// assumes a single 250 MHz core clock and integer fixed-point units
package hpw_pkg;
    localparam int CLK_MHZ = 250;
    // times in microseconds and their cycle counts
    localparam int PAUSE_US = 100;
    localparam int PAUSE_CYC = PAUSE_US * CLK_MHZ;
    localparam int CYCLE_KNEE_US = 2640;
    localparam int KNEE_CYC = CYCLE_KNEE_US * CLK_MHZ;
    localparam int MAX_PULSE_US = 2000;
    localparam int MAX_PULSE_CYC = MAX_PULSE_US * CLK_MHZ;
    localparam int CNT_W = 24;
    localparam logic [23:0] ELAPSED_MAX = 24'hffffff;
    // energy in 1e-6 mJ, coefficients in 1e-6 mJ per degree
    localparam int REF_TEMP_C = 25;
    localparam logic [19:0] REF_STD_ENERGY = 20'h4bd48;
    localparam logic [15:0] REF_TEMP_COEF = 16'h0d42;
    // resistances in milliohm
    localparam int HEATER_MOHM = 1500000;
    localparam int INT_WIRING_5V_MOHM = 40000;
    localparam int INT_WIRING_3V_MOHM = 55000;
    localparam int COMMON_WIRING_MOHM = 320;
    // adjusted voltage: gain in thousandths, offset in mV
    localparam int V_GAIN_PPT = 968;
    localparam int V_GAIN_DIV = 1000;
    localparam int V_OFFSET_MV = 598;
    // cycle coefficient in ppm; slopes in thousandths of a ppm per microsecond
    localparam int C_SLOPE_LO = 132151;
    localparam int C_OFFS_LO = 360000;
    localparam int C_SLOPE_HI = 80812;
    localparam int C_OFFS_HI = 496000;
    localparam int C_ONE = 1000000;
    localparam int C_DIV = CLK_MHZ * 1000;
    // e * s^2 * c / (rh * v^2) scaled to core clock cycles
    localparam int SCALE_DIV = 1000000000 / (CLK_MHZ * 1000);
    // thermistor protection thresholds in ohm
    localparam logic [19:0] OVERHEAT_SET_OHMS = 20'h00ed8;
    localparam logic [19:0] OVERHEAT_CLEAR_OHMS = 20'h01d1a;
    // thermistor table, 5 degree steps from -20 degrees, ohm
    localparam int THERM_N = 25;
    localparam int THERM_T0 = -20;
    localparam int THERM_STEP = 5;
    localparam logic [19:0] THERM_OHMS [THERM_N] = '{
        20'h4d62a, 20'h392ec, 20'h2abdc, 20'h204c2, 20'h18a7e,
        20'h13014, 20'h0ec9c, 20'h0b9ac, 20'h092ea, 20'h07530,
        20'h05e2e, 20'h04c36, 20'h03e12, 20'h032e6, 20'h029fe,
        20'h022d8, 20'h01d1a, 20'h0186a, 20'h01496, 20'h0117e,
        20'h00ed8, 20'h00cb2, 20'h00ae6, 20'h00962, 20'h0082a};
    // divider widths
    localparam int NUM_W = 96;
    localparam int DEN_W = 72;
endpackage : hpw_pkg

// ==== verilog/hpw_divider.sv ====
// iterative restoring unsigned divider, one quotient bit per clock
// assumes start only while not busy; denominator nonzero
`timescale 1ns/1ns
module hpw_divider #(
    parameter int NUM_W = hpw_pkg::NUM_W,
    parameter int DEN_W = hpw_pkg::DEN_W
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [NUM_W-1:0] numer,
    input wire logic [DEN_W-1:0] denom,
    output logic busy,
    output logic done,
    output logic [NUM_W-1:0] quotient
);
    import hpw_pkg::*;

    localparam int IW = $clog2(NUM_W + 1);
    logic [DEN_W:0] rem_reg;
    logic [DEN_W-1:0] den_reg;
    logic [IW-1:0] cnt_reg;
    logic [DEN_W:0] shifted;
    logic take;

    assign shifted = {rem_reg[DEN_W-1:0], quotient[NUM_W-1]};
    assign take = shifted >= {1'b0, den_reg};

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rem_reg <= '0;
            den_reg <= '0;
            cnt_reg <= '0;
            quotient <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem_reg <= '0;
                den_reg <= denom;
                quotient <= numer;
                cnt_reg <= IW'(NUM_W);
                busy <= 1'b1;
            end else if (busy) begin
                rem_reg <= take ? shifted - {1'b0, den_reg} : shifted;
                quotient <= {quotient[NUM_W-2:0], take};
                cnt_reg <= cnt_reg - 1'b1;
                if (cnt_reg == IW'(1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule : hpw_divider

// ==== verilog/hpw_calculator.sv ====
// heat pulse width calculator and strobe timer for a thermal print head
// assumes thermistor resistance, supply and paper constants arrive as
// synchronous binary words from the surrounding controller
//
// Function
// RULE_01 - width is E times R over V squared, times C
// RULE_02 - energy falls with temperature above 25 degrees
// RULE_03 - temperature comes from head thermistor resistance
// RULE_04 - paper energy and split coefficients are inputs
// RULE_05 - adjusted resistance from heater, wiring and dots
// RULE_06 - internal wiring 40 or 55 ohm by supply
// RULE_07 - common wiring 0.32 ohm plus external wiring
// RULE_08 - adjusted voltage is 0.968 Vp minus 0.598
// RULE_09 - cycle coefficient has two slopes at 2640 us
// RULE_10 - cycle coefficient clamped to one
// RULE_11 - cycle measured start to start of activations
// RULE_12 - next start exceeds width plus 100 us
// RULE_13 - pulse width limited to protect head life
// RULE_14 - stop above 80, resume below 60 degrees
// RULE_15 - recompute per line, strobe counted in cycles
`timescale 1ns/1ns
module hpw_calculator #(
    parameter int PAUSE_CYCLES = hpw_pkg::PAUSE_CYC,
    parameter int KNEE_CYCLES = hpw_pkg::KNEE_CYC,
    parameter int MAX_PULSE_CYCLES = hpw_pkg::MAX_PULSE_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic line_req,
    output logic line_ready,
    output logic line_done,
    input wire logic [8:0] active_dot_count,
    input wire logic [19:0] head_thermistor_ohms,
    input wire logic [15:0] head_drive_voltage_mv,
    input wire logic logic_supply_low,
    input wire logic [15:0] external_wiring_resistance_mohm,
    input wire logic [19:0] standard_print_energy,
    input wire logic [15:0] energy_temp_coefficient_low,
    input wire logic [15:0] energy_temp_coefficient_high,
    output logic head_strobe,
    output logic overheat,
    output logic signed [7:0] head_temp_c,
    output logic [hpw_pkg::CNT_W-1:0] pulse_cycles
);
    import hpw_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_GAP,
        ST_PREP,
        ST_MUL,
        ST_DIV,
        ST_FIRE
    } hpw_state_e;

    hpw_state_e state_reg;
    logic [CNT_W-1:0] elapsed_reg;
    logic [CNT_W-1:0] last_width_reg;
    logic [CNT_W-1:0] w_cap_reg;
    logic [CNT_W-1:0] strobe_cnt_reg;
    logic [8:0] dots_reg;
    logic [21:0] e_reg;
    logic [25:0] sum_reg;
    logic [15:0] v_reg;
    logic [19:0] c_reg;
    logic [NUM_W-1:0] num_reg;
    logic [DEN_W-1:0] den_reg;
    logic div_start_reg;
    logic div_done;
    logic [NUM_W-1:0] div_quo;

    // thermistor lookup: count table points whose resistance is not below
    logic [THERM_N-1:0] therm_hit;
    logic [4:0] hit_count;
    logic signed [7:0] temp_now;

    genvar g;
    generate
        for (g = 0; g < THERM_N; g++) begin : g_therm
            assign therm_hit[g] = head_thermistor_ohms <= THERM_OHMS[g]; // RULE_03
        end
    endgenerate

    always_comb begin
        hit_count = '0;
        for (int i = 0; i < THERM_N; i++) begin
            hit_count = hit_count + 5'(therm_hit[i]);
        end
    end

    // rounds toward the colder table point
    assign temp_now = (hit_count == 5'h00) ? 8'(THERM_T0)
                    : 8'(THERM_T0 + THERM_STEP * (int'(hit_count) - 1)); // RULE_03

    // energy from paper constants and head temperature
    logic [15:0] tc_sel;
    int e_int;
    logic [21:0] e_val;
    assign tc_sel = (int'(temp_now) < REF_TEMP_C) ? energy_temp_coefficient_low
                                                  : energy_temp_coefficient_high; // RULE_04
    assign e_int = int'(standard_print_energy) - int'(tc_sel) * (int'(temp_now) - REF_TEMP_C); // RULE_02
    assign e_val = (e_int < 0) ? 22'h000000 : 22'(e_int);

    // wiring-corrected resistance sum, milliohm
    logic [25:0] ri_val;
    logic [25:0] drop_val;
    logic [25:0] sum_val;
    assign ri_val = logic_supply_low ? 26'(INT_WIRING_3V_MOHM) : 26'(INT_WIRING_5V_MOHM); // RULE_06
    assign drop_val = 26'(({10'h000, external_wiring_resistance_mohm} + 26'(COMMON_WIRING_MOHM))
                      * {17'h00000, dots_reg}); // RULE_07
    assign sum_val = 26'(HEATER_MOHM) + ri_val + drop_val; // RULE_05

    // adjusted voltage, mV
    int v_int;
    logic [15:0] v_val;
    assign v_int = (int'(head_drive_voltage_mv) * V_GAIN_PPT) / V_GAIN_DIV - V_OFFSET_MV; // RULE_08
    assign v_val = (v_int <= 0) ? 16'h0000 : 16'(v_int);

    // cycle coefficient from captured start-to-start time, ppm
    logic [63:0] c_prod;
    logic [63:0] c_calc;
    logic [19:0] c_val;
    always_comb begin
        if (int'(w_cap_reg) < KNEE_CYCLES) begin
            c_prod = 64'(C_SLOPE_LO) * {40'h0, w_cap_reg}; // RULE_09
            c_calc = c_prod / 64'(C_DIV) + 64'(C_OFFS_LO);
        end else begin
            c_prod = 64'(C_SLOPE_HI) * {40'h0, w_cap_reg}; // RULE_09
            c_calc = c_prod / 64'(C_DIV) + 64'(C_OFFS_HI);
        end
        c_val = (c_calc > 64'(C_ONE)) ? 20'(C_ONE) : c_calc[19:0]; // RULE_10
    end

    logic [CNT_W:0] gap_need;
    logic gap_ok;
    logic fire_start;
    logic [NUM_W-1:0] width_full;
    logic [CNT_W-1:0] width_val;
    assign gap_need = {1'b0, last_width_reg} + (CNT_W + 1)'(PAUSE_CYCLES);
    assign gap_ok = {1'b0, elapsed_reg} > gap_need; // RULE_12
    assign width_full = (div_quo > NUM_W'(MAX_PULSE_CYCLES)) ? NUM_W'(MAX_PULSE_CYCLES) : div_quo; // RULE_13
    assign width_val = width_full[CNT_W-1:0];
    // a head that turned hot during the divide gets no strobe for this line
    assign fire_start = (state_reg == ST_DIV) && div_done && (width_val != '0) && !overheat; // RULE_14
    assign line_ready = (state_reg == ST_IDLE);

    // sequencer
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (line_req) begin
                        state_reg <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (gap_ok && !overheat) begin // RULE_14
                        state_reg <= ST_PREP;
                    end
                end
                ST_PREP: state_reg <= ST_MUL;
                ST_MUL: begin
                    if (e_reg == '0 || v_reg == '0) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        state_reg <= ST_DIV;
                    end
                end
                ST_DIV: begin
                    if (div_done) begin
                        state_reg <= fire_start ? ST_FIRE : ST_IDLE;
                    end
                end
                ST_FIRE: begin
                    if (overheat || strobe_cnt_reg == CNT_W'(1)) begin // RULE_14
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // time since the last activation start, saturating
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            elapsed_reg <= ELAPSED_MAX;
            last_width_reg <= '0;
            w_cap_reg <= ELAPSED_MAX;
        end else begin
            if (fire_start) begin
                elapsed_reg <= CNT_W'(1); // RULE_11
                last_width_reg <= width_val;
            end else if (elapsed_reg != ELAPSED_MAX) begin
                elapsed_reg <= elapsed_reg + 1'b1;
            end
            if (state_reg == ST_GAP && gap_ok && !overheat) begin
                w_cap_reg <= elapsed_reg; // RULE_11
            end
        end
    end

    // arithmetic pipeline, recomputed for every line
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dots_reg <= '0;
            e_reg <= '0;
            sum_reg <= '0;
            v_reg <= '0;
            c_reg <= '0;
            num_reg <= '0;
            den_reg <= '0;
            div_start_reg <= 1'b0;
            pulse_cycles <= '0;
        end else begin
            div_start_reg <= 1'b0;
            if (state_reg == ST_IDLE && line_req) begin
                dots_reg <= active_dot_count;
            end
            if (state_reg == ST_PREP) begin // RULE_15
                e_reg <= e_val;
                sum_reg <= sum_val;
                v_reg <= v_val;
                c_reg <= c_val;
            end
            if (state_reg == ST_MUL) begin
                num_reg <= NUM_W'(e_reg) * NUM_W'(sum_reg) * NUM_W'(sum_reg) * NUM_W'(c_reg); // RULE_01
                den_reg <= DEN_W'(HEATER_MOHM) * DEN_W'(v_reg) * DEN_W'(v_reg) * DEN_W'(SCALE_DIV); // RULE_01
                div_start_reg <= (e_reg != '0) && (v_reg != '0);
                if (e_reg == '0 || v_reg == '0) begin
                    pulse_cycles <= '0;
                end
            end
            if (state_reg == ST_DIV && div_done) begin
                pulse_cycles <= width_val;
            end
        end
    end

    hpw_divider #(
        .NUM_W(NUM_W),
        .DEN_W(DEN_W)
    ) u_div (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .start(div_start_reg),
        .numer(num_reg),
        .denom(den_reg),
        .busy(),
        .done(div_done),
        .quotient(div_quo)
    );

    // strobe timer
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            head_strobe <= 1'b0;
            strobe_cnt_reg <= '0;
            line_done <= 1'b0;
        end else begin
            line_done <= 1'b0;
            if (fire_start) begin
                head_strobe <= 1'b1; // RULE_15
                strobe_cnt_reg <= width_val;
            end else if (state_reg == ST_FIRE) begin
                strobe_cnt_reg <= strobe_cnt_reg - 1'b1;
                if (overheat || strobe_cnt_reg == CNT_W'(1)) begin // RULE_14
                    head_strobe <= 1'b0;
                    line_done <= 1'b1;
                end
            end
            if ((state_reg == ST_MUL && (e_reg == '0 || v_reg == '0))
                || (state_reg == ST_DIV && div_done && !fire_start)) begin
                line_done <= 1'b1;
            end
        end
    end

    // overheat hysteresis and temperature report
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            overheat <= 1'b0;
            head_temp_c <= '0;
        end else begin
            head_temp_c <= temp_now;
            if (head_thermistor_ohms <= OVERHEAT_SET_OHMS) begin
                overheat <= 1'b1; // RULE_14
            end else if (head_thermistor_ohms >= OVERHEAT_CLEAR_OHMS) begin
                overheat <= 1'b0; // RULE_14
            end
        end
    end
endmodule : hpw_calculator

// ==== tb/hpw_calculator_chk.sv ====
// port checker for the heat pulse width calculator
// bound to hpw_calculator; sees only its top ports
`timescale 1ns/1ns
module hpw_calculator_chk #(
    parameter int PAUSE_CYCLES = 20
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic line_ready,
    input wire logic line_done,
    input wire logic [19:0] head_thermistor_ohms,
    input wire logic head_strobe,
    input wire logic overheat,
    input wire logic signed [7:0] head_temp_c,
    input wire logic [hpw_pkg::CNT_W-1:0] pulse_cycles
);
    import hpw_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [23:0] run_reg;
    logic [31:0] since_reg;
    logic [23:0] prev_w_reg;
    logic strobe_d_reg;
    // cycles the strobe has been high so far
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) run_reg <= 24'h0;
        else run_reg <= head_strobe ? run_reg + 24'h1 : 24'h0;
    end
    // distance between strobe starts, width of the previous line
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            since_reg <= 32'hffffffff;
            prev_w_reg <= 24'h0;
            strobe_d_reg <= 1'b0;
        end else begin
            strobe_d_reg <= head_strobe;
            if (head_strobe && !strobe_d_reg) begin
                since_reg <= 32'h1;
                prev_w_reg <= pulse_cycles;
            end else if (since_reg != 32'hffffffff) begin
                since_reg <= since_reg + 32'h1;
            end
        end
    end
    sequence strobe_fall_s;
        $fell(head_strobe) && !$past(overheat);
    endsequence
    strobe_hold_a: assert property (head_strobe && !overheat |-> run_reg < pulse_cycles)
        else $error("strobe longer than computed width");
    strobe_len_a: assert property (strobe_fall_s |-> run_reg == pulse_cycles)
        else $error("strobe shorter than computed width");
    strobe_done_a: assert property ($fell(head_strobe) |-> line_done)
        else $error("line done missing at strobe end");
    done_pulse_a: assert property (line_done |=> !line_done)
        else $error("line done longer than one cycle");
    hot_block_a: assert property (overheat |=> !head_strobe)
        else $error("strobe while overheated");
    hot_set_a: assert property (head_thermistor_ohms <= OVERHEAT_SET_OHMS |=> overheat)
        else $error("overheat not set");
    hot_hold_a: assert property (head_thermistor_ohms > OVERHEAT_SET_OHMS &&
        head_thermistor_ohms < OVERHEAT_CLEAR_OHMS |=> $stable(overheat))
        else $error("overheat changed inside hysteresis band");
    hot_clear_a: assert property (head_thermistor_ohms >= OVERHEAT_CLEAR_OHMS |=> !overheat)
        else $error("overheat not cleared");
    start_gap_a: assert property ($rose(head_strobe) |->
        since_reg > 32'(prev_w_reg) + 32'(PAUSE_CYCLES))
        else $error("strobe starts too close");
    temp_table_a: assert property (head_thermistor_ohms == 20'h07530 |=> head_temp_c == 8'sh19)
        else $error("wrong temperature for table point");
    busy_strobe_a: assert property (head_strobe |-> !line_ready)
        else $error("ready during strobe");
endmodule : hpw_calculator_chk

bind hpw_calculator hpw_calculator_chk #(.PAUSE_CYCLES(PAUSE_CYCLES)) u_hpw_calculator_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .line_ready(line_ready), .line_done(line_done),
    .head_thermistor_ohms(head_thermistor_ohms), .head_strobe(head_strobe), .overheat(overheat),
    .head_temp_c(head_temp_c), .pulse_cycles(pulse_cycles));

// ==== tb/hpw_head_model.sv ====
// print head model: thermistor level and strobe timing monitor
// assumes one core clock; thermistor value set by the bench
`timescale 1ns/1ns
module hpw_head_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic head_strobe,
    input wire logic [19:0] ohms_set,
    output logic [19:0] head_thermistor_ohms,
    output logic [23:0] strobe_len,
    output logic [31:0] start_gap,
    output logic [31:0] start_cnt
);
    logic prev_reg;
    logic [31:0] since_reg;
    assign head_thermistor_ohms = ohms_set;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_reg <= 1'b0;
            since_reg <= 32'hffffffff;
            strobe_len <= 24'h0;
            start_gap <= 32'h0;
            start_cnt <= 32'h0;
        end else begin
            prev_reg <= head_strobe;
            if (head_strobe && !prev_reg) begin
                start_gap <= since_reg;
                start_cnt <= start_cnt + 32'h1;
                strobe_len <= 24'h1;
                since_reg <= 32'h1;
            end else begin
                if (head_strobe) strobe_len <= strobe_len + 24'h1;
                if (since_reg != 32'hffffffff) since_reg <= since_reg + 32'h1;
            end
        end
    end
endmodule : hpw_head_model

// ==== tb/hpw_calculator_bench.sv ====
// self-checking bench for the heat pulse width calculator
// shortened pause, knee and maximum width parameters
`timescale 1ns/1ns
module hpw_calculator_bench;
    import hpw_pkg::*;
    localparam int PAUSE = 20;
    localparam int KNEE = 2000;
    localparam int MAXC = 4000;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic line_req = 1'b0;
    logic low = 1'b0;
    logic [8:0] dots = 9'h0;
    logic [19:0] ohms = 20'h07530;
    logic [19:0] energy = 20'h0;
    logic [15:0] vp = 16'h0;
    logic [15:0] rc = 16'h0;
    logic ready, done, strobe, ovh;
    logic signed [7:0] temp;
    logic [23:0] pw, slen;
    logic [19:0] th;
    logic [31:0] gap, starts;
    int error_cnt = 0;
    int tests_run = 0;

    hpw_calculator #(.PAUSE_CYCLES(PAUSE), .KNEE_CYCLES(KNEE), .MAX_PULSE_CYCLES(MAXC)) u_hpw_calculator (
        .core_clk(core_clk), .sys_rst(sys_rst), .line_req(line_req), .line_ready(ready),
        .line_done(done), .active_dot_count(dots), .head_thermistor_ohms(th),
        .head_drive_voltage_mv(vp), .logic_supply_low(low), .external_wiring_resistance_mohm(rc),
        .standard_print_energy(energy), .energy_temp_coefficient_low(16'h0007),
        .energy_temp_coefficient_high(16'h0014), .head_strobe(strobe), .overheat(ovh),
        .head_temp_c(temp), .pulse_cycles(pw));
    hpw_head_model u_hpw_head_model (.core_clk(core_clk), .sys_rst(sys_rst), .head_strobe(strobe),
        .ohms_set(ohms), .head_thermistor_ohms(th), .strobe_len(slen), .start_gap(gap), .start_cnt(starts));

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk

    task automatic chk_rng(input string what, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
        tests_run++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_rng

    // expected width in cycles; c in ppm
    function automatic logic [23:0] exp_w(input int e, input int n, input int v, input int lo, input int r, input int c);
        logic [127:0] s, a, q;
        if (e <= 0) return 24'h0;
        s = 128'(1500000 + (lo != 0 ? 55000 : 40000) + (320 + r) * n);
        a = 128'((968 * v) / 1000 - 598);
        q = (128'(e) * s * s * 128'(c)) / (128'(1500000) * a * a * 128'(4000));
        return (q > 128'(MAXC)) ? 24'(MAXC) : 24'(q);
    endfunction : exp_w

    function automatic int cfun(input int w);
        longint t;
        t = (w < KNEE) ? 132151 * longint'(w) / 250000 + 360000 : 80812 * longint'(w) / 250000 + 496000;
        return (t > 1000000) ? 1000000 : int'(t);
    endfunction : cfun

    task automatic rst;
        @(negedge core_clk);
        sys_rst = 1'b1;
        repeat (16) @(negedge core_clk);
        sys_rst = 1'b0;
    endtask : rst

    task automatic set_in(input int oh, input int n, input int v, input int lo, input int r, input int e);
        @(negedge core_clk);
        ohms = 20'(oh);
        dots = 9'(n);
        vp = 16'(v);
        low = lo[0];
        rc = 16'(r);
        energy = 20'(e);
    endtask : set_in

    task automatic wait_done;
        for (int i = 0; i < 20000 && done !== 1'b1; i++) @(negedge core_clk);
        chk("line done", 32'h1, {31'h0, done});
        chk("ready after line", 32'h1, {31'h0, ready});
    endtask : wait_done

    task automatic do_line;
        for (int i = 0; i < 1000 && ready !== 1'b1; i++) @(negedge core_clk);
        line_req = 1'b1;
        @(negedge core_clk);
        line_req = 1'b0;
        chk("busy after request", 32'h0, {31'h0, ready});
        wait_done();
        @(negedge core_clk);
    endtask : do_line

    task automatic t_formula;
        int oh[3] = '{30000, 10750, 100990};
        int tc[3] = '{25, 50, 0};
        int nn[3] = '{100, 288, 0};
        int vv[3] = '{24000, 26400, 21600};
        int lw[3] = '{0, 1, 0};
        int rr[3] = '{0, 500, 100};
        int e;
        for (int k = 0; k < 3; k++) begin
            e = 1000 - (tc[k] < 25 ? 7 : 20) * (tc[k] - 25);
            set_in(oh[k], nn[k], vv[k], lw[k], rr[k], 1000);
            rst();
            do_line();
            chk("width", exp_w(e, nn[k], vv[k], lw[k], rr[k], 1000000), pw);
            chk("strobe", exp_w(e, nn[k], vv[k], lw[k], rr[k], 1000000), slen);
            chk("temp", 32'(tc[k]), {24'h0, temp});
        end
    endtask : t_formula

    task automatic t_cycle;
        logic [31:0] w1;
        int g;
        set_in(30000, 100, 24000, 0, 0, 1000);
        rst();
        do_line();
        w1 = pw;
        do_line();
        g = int'(gap);
        chk_rng("start gap", w1 + PAUSE + 1, 32'hffffffff, gap);
        chk_rng("short cycle width", exp_w(1000, 100, 24000, 0, 0, cfun(g - 110)),
            exp_w(1000, 100, 24000, 0, 0, cfun(g)), pw);
        repeat (2500) @(negedge core_clk);
        do_line();
        g = int'(gap);
        chk_rng("long cycle width", exp_w(1000, 100, 24000, 0, 0, cfun(g - 110)),
            exp_w(1000, 100, 24000, 0, 0, cfun(g)), pw);
    endtask : t_cycle

    task automatic t_limits;
        logic [31:0] s;
        set_in(30000, 100, 24000, 0, 0, 1048575);
        rst();
        do_line();
        chk("clamped width", MAXC, pw);
        chk("clamped strobe", MAXC, slen);
        set_in(30000, 100, 24000, 0, 0, 0);
        s = starts;
        do_line();
        chk("zero width", 32'h0, pw);
        chk("no strobe", s, starts);
        set_in(30000, 100, 600, 0, 0, 1000);
        do_line();
        chk("zero volt width", 32'h0, pw);
        chk("no volt strobe", s, starts);
    endtask : t_limits

    task automatic t_overheat;
        logic [31:0] s;
        set_in(30000, 100, 24000, 0, 0, 1048575);
        rst();
        line_req = 1'b1;
        @(negedge core_clk);
        line_req = 1'b0;
        for (int i = 0; i < 300 && strobe !== 1'b1; i++) @(negedge core_clk);
        repeat (10) @(negedge core_clk);
        ohms = 20'h00ed8;
        wait_done();
        @(negedge core_clk);
        chk_rng("cut strobe", 32'h1, MAXC - 1, slen);
        chk("hot", 32'h1, {31'h0, ovh});
        ohms = 20'h01d19;
        s = starts;
        line_req = 1'b1;
        @(negedge core_clk);
        line_req = 1'b0;
        repeat (300) @(negedge core_clk);
        chk("held off", s, starts);
        chk("still hot", 32'h1, {31'h0, ovh});
        ohms = 20'h01d1a;
        wait_done();
        chk("resumed", s + 1, starts);
        chk("cooled", 32'h0, {31'h0, ovh});
    endtask : t_overheat

    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    initial begin
        rst();
        t_formula();
        t_cycle();
        t_limits();
        t_overheat();
        end_of_test();
    end

    // hang guard, well beyond the expected run
    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        end_of_test();
    end
endmodule : hpw_calculator_bench
